// ===== verilog/lcs_link_regs.v
// Link control bits and self-ID buffer pointer / tally registers of a
// host-bus to serial-bus bridge, with the PHY-clock access guard.
// Assumes a one-cycle host register strobe port on clk, self-ID events
// from the link core on clk, and a PHY-clock-running level from a pin.
// Limitation: the first accesses to the PHY window after that clock starts
// still abort until the synchronised level catches up.
//
// What this block does
// - Access to PHY-clock registers while that clock stops ends in target abort.
// - With abort suppress set, such reads complete and return all ones.
// - Offsets DCh-F0h and 100h-11Ch belong to the PHY-clock domain.
// - Bit 18 allows posted writes; changed only while link online is 0.
// - Bit 17 link online clears on hardware and software reset.
// - With link online 0 the link takes, handles and sends no packets.
// - Writing 1 to bit 16 resets link state and registers, flushes FIFOs.
// - Bit 16 reads 1 during software reset, then returns to 0 itself.
// - Control bits 15 to 0 always read zero.
// - Self-ID base keeps bits 31 to 11; bits 10 to 0 read zero.
// - Self-ID packets are stored from the address in the base register.
// - Tally bit 31 flags an error in the latest self-ID reception.
// - Generation field 23 to 16 counts bus resets only while the link is powered and online, wrapping after 255.
// - Size field 10 to 2 counts stored quadlets, cleared at reception start.
// - Tally bits 30-24, 15-11 and 1-0 always read zero.
// - Bit 19 link power on must be 1 for any link-to-PHY traffic.
`include "lcs_link_map.vh"
`timescale 1ns/1ps
`default_nettype none

module lcs_link_regs #(
    parameter REINIT_CYCLES = 16
) (
    input wire clk,
    input wire rstn,
    input wire hostReq,
    input wire hostWrite,
    input wire [11:0] hostAddr,
    input wire [31:0] hostWdata,
    output reg hostAck,
    output reg hostAbort,
    output reg [31:0] hostRdata,
    input wire abortSuppress,
    input wire phyClkRunning,
    input wire busResetSeen,
    input wire selfIdStart,
    input wire selfIdQuadlet,
    input wire selfIdFault,
    input wire selfIdDone,
    output reg linkPowerOn,
    output reg postedWriteAllow,
    output reg linkOnline,
    output reg packetsAllowed,
    output reg reinitActive,
    output reg [31:0] selfIdWriteAddr
);

    // Five-bit sequencer count; keep REINIT_CYCLES between 1 and 31
    // because 0 would underflow and larger values are cut.
    localparam [4:0] REINIT_LEN = REINIT_CYCLES[4:0];

    // Offset decode for the PHY-clock windows, used by reads and writes
    function inPhyDomain;
        input [11:0] a;
        begin
            inPhyDomain = ((a >= `LCS_PHY_LO_A) && (a <= `LCS_PHY_HI_A)) ||
                          ((a >= `LCS_PHY_LO_B) && (a <= `LCS_PHY_HI_B));
        end
    endfunction

    // Pin synchroniser for the PHY clock status; stage one feeds stage two only
    // Waiting for stages two and three to agree costs a cycle but drops
    // a single unsettled sample before it can change the abort decision
    reg phyS1_reg;
    reg phyS2_reg;
    reg phyS3_reg;
    reg phyRun_reg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phyS1_reg <= 1'b0;
            phyS2_reg <= 1'b0;
            phyS3_reg <= 1'b0;
            phyRun_reg <= 1'b0;
        end else begin
            phyS1_reg <= phyClkRunning;
            phyS2_reg <= phyS1_reg;
            phyS3_reg <= phyS2_reg;
            if (phyS2_reg == phyS3_reg) begin
                phyRun_reg <= phyS3_reg; // Accept only a settled level
            end
        end
    end

    // Control, software reset and self-ID state
    reg power_reg;
    reg posted_reg;
    reg online_reg;
    reg reinit_reg;
    reg [4:0] reinitCnt_reg;
    reg [`LCS_BASE_W-1:0] base_reg;
    reg idFault_reg;
    reg faultSeen_reg;
    reg [`LCS_GEN_W-1:0] gen_reg;
    reg [`LCS_SIZE_W-1:0] size_reg;

    // Host strobe decode; a blocked write is dropped whole, never half applied
    wire wrStrobe = hostReq && hostWrite;
    wire phyBlocked = inPhyDomain(hostAddr) && !phyRun_reg;
    wire wrOk = wrStrobe && !phyBlocked;
    wire wrSet = wrOk && (hostAddr == `LCS_OFS_CTRL_SET);
    wire wrClr = wrOk && (hostAddr == `LCS_OFS_CTRL_CLR);
    // Events count only while the link is powered, online and not resetting
    wire linkLive = power_reg && online_reg && !reinit_reg;
    wire startEv = linkLive && selfIdStart;
    wire quadEv = linkLive && selfIdQuadlet;
    wire faultEv = linkLive && selfIdFault;
    wire doneEv = linkLive && selfIdDone;

    // Next control bits; soft reset puts the reset values back
    reg power_next;
    reg posted_next;
    reg online_next;
    always @* begin
        power_next = power_reg;
        posted_next = posted_reg;
        online_next = online_reg;
        if (reinit_reg) begin
            power_next = 1'b0;
            posted_next = 1'b0;
            online_next = 1'b0;
        end else begin
            if (wrSet && hostWdata[`LCS_BIT_POWER]) begin
                power_next = 1'b1;
            end else if (wrClr && hostWdata[`LCS_BIT_POWER]) begin
                power_next = 1'b0;
            end
            // Changing posted mode under live traffic would reorder writes
            if (!online_reg) begin
                if (wrSet && hostWdata[`LCS_BIT_POSTED]) begin
                    posted_next = 1'b1;
                end else if (wrClr && hostWdata[`LCS_BIT_POSTED]) begin
                    posted_next = 1'b0;
                end
            end
            if (wrSet && hostWdata[`LCS_BIT_ONLINE]) begin
                online_next = 1'b1;
            end else if (wrClr && hostWdata[`LCS_BIT_ONLINE]) begin
                online_next = 1'b0; // Takes effect next cycle
            end
        end
    end

    // Control bits register their next values on every edge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_reg <= 1'b0;
            posted_reg <= 1'b0;
            online_reg <= 1'b0;
        end else begin
            power_reg <= power_next;
            posted_reg <= posted_next;
            online_reg <= online_next;
        end
    end

    // Software reset sequencer; the bit self-clears when the count ends
    reg reinit_next;
    reg [4:0] reinitCnt_next;
    always @* begin
        reinit_next = reinit_reg;
        reinitCnt_next = reinitCnt_reg;
        if (reinit_reg) begin
            if (reinitCnt_reg == `LCS_CNT_ZERO) begin
                reinit_next = 1'b0;
            end else begin
                reinitCnt_next = reinitCnt_reg - `LCS_CNT_STEP;
            end
        end else if (wrSet && hostWdata[`LCS_BIT_REINIT]) begin
            // A second request while running is ignored, not restarted
            reinit_next = 1'b1;
            reinitCnt_next = REINIT_LEN - `LCS_CNT_STEP;
        end
    end

    // Reset sequencer state
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reinit_reg <= 1'b0;
            reinitCnt_reg <= `LCS_CNT_ZERO;
        end else begin
            reinit_reg <= reinit_next;
            reinitCnt_reg <= reinitCnt_next;
        end
    end

    // Self-ID buffer base; low eleven bits are never stored
    reg [`LCS_BASE_W-1:0] base_next;
    always @* begin
        base_next = base_reg;
        if (reinit_reg) begin
            base_next = `LCS_BASE_RST;
        end else if (wrOk && (hostAddr == `LCS_OFS_SID_BASE)) begin
            base_next = hostWdata[`LCS_BASE_MSB:`LCS_BASE_LSB];
        end
    end

    // Base register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            base_reg <= `LCS_BASE_RST;
        end else begin
            base_reg <= base_next;
        end
    end

    // Self-ID tally next value: hardware only, host writes never reach it
    reg idFault_next;
    reg faultSeen_next;
    reg [`LCS_GEN_W-1:0] gen_next;
    reg [`LCS_SIZE_W-1:0] size_next;
    always @* begin
        idFault_next = idFault_reg;
        faultSeen_next = faultSeen_reg;
        gen_next = gen_reg;
        size_next = size_reg;
        if (busResetSeen && linkLive) begin
            gen_next = gen_reg + `LCS_GEN_STEP; // Wraps 255 to 0
        end
        if (startEv) begin
            size_next = `LCS_SIZE_RST;
        end else if (quadEv && (size_reg != `LCS_SIZE_MAX)) begin
            // Saturate rather than wrap so an overrun never looks short
            size_next = size_reg + `LCS_SIZE_STEP;
        end
        // A fault in the closing cycle still counts for this reception
        if (startEv) begin
            faultSeen_next = faultEv;
        end else if (doneEv) begin
            faultSeen_next = 1'b0;
        end else if (faultEv) begin
            faultSeen_next = 1'b1;
        end
        if (doneEv) begin
            idFault_next = faultSeen_reg || faultEv;
        end
    end

    // Self-ID tally registers; no host write path exists
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idFault_reg <= 1'b0;
            faultSeen_reg <= 1'b0;
            gen_reg <= `LCS_GEN_RST;
            size_reg <= `LCS_SIZE_RST;
        end else if (reinit_reg) begin
            idFault_reg <= 1'b0;
            faultSeen_reg <= 1'b0;
            gen_reg <= `LCS_GEN_RST;
            size_reg <= `LCS_SIZE_RST;
        end else begin
            idFault_reg <= idFault_next;
            faultSeen_reg <= faultSeen_next;
            gen_reg <= gen_next;
            size_reg <= size_next;
        end
    end

    // Read data mux with reserved bits forced to zero
    // Unmapped offsets fall into the default and read as zero
    reg [31:0] readData;
    always @* begin
        readData = `LCS_ZERO32;
        case (hostAddr)
            `LCS_OFS_CTRL_SET, `LCS_OFS_CTRL_CLR: begin
                readData[`LCS_BIT_POWER] = power_reg;
                readData[`LCS_BIT_POSTED] = posted_reg;
                readData[`LCS_BIT_ONLINE] = online_reg;
                readData[`LCS_BIT_REINIT] = reinit_reg;
            end
            `LCS_OFS_SID_BASE: begin
                readData[`LCS_BASE_MSB:`LCS_BASE_LSB] = base_reg;
            end
            `LCS_OFS_SID_TALLY: begin
                readData[`LCS_TALLY_ERR] = idFault_reg;
                readData[`LCS_GEN_MSB:`LCS_GEN_LSB] = gen_reg;
                readData[`LCS_SIZE_MSB:`LCS_SIZE_LSB] = size_reg;
            end
            default: begin
                readData = `LCS_ZERO32;
            end
        endcase
    end

    // Host answer one cycle after the strobe; abort or all ones when blocked
    reg ack_next;
    reg abort_next;
    reg [31:0] rdata_next;
    always @* begin
        ack_next = hostReq && !(phyBlocked && !abortSuppress);
        abort_next = hostReq && phyBlocked && !abortSuppress;
        rdata_next = `LCS_ZERO32;
        if (hostReq && !hostWrite && !abort_next) begin
            // A stopped PHY clock answers all ones instead of stale data
            rdata_next = phyBlocked ? `LCS_ONES32 : readData;
        end
    end

    // Answer registers; data stands only in the acknowledge cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hostAck <= 1'b0;
            hostAbort <= 1'b0;
            hostRdata <= `LCS_ZERO32;
        end else begin
            hostAck <= ack_next;
            hostAbort <= abort_next;
            hostRdata <= rdata_next;
        end
    end

    // Registered copies of control state for the link core and PHY side
    // Flops on every output keep the link core free of decode glitches
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            linkPowerOn <= 1'b0;
            postedWriteAllow <= 1'b0;
            linkOnline <= 1'b0;
            packetsAllowed <= 1'b0;
            reinitActive <= 1'b0;
            selfIdWriteAddr <= `LCS_ZERO32;
        end else begin
            linkPowerOn <= power_reg && !reinit_reg;
            postedWriteAllow <= posted_reg;
            linkOnline <= online_reg;
            packetsAllowed <= linkLive;
            reinitActive <= reinit_reg; // Flushes FIFOs
            // Next store address: base plus quadlets already written
            selfIdWriteAddr <= {base_reg, 11'h000} +
                               {21'h00_0000, size_reg, 2'b00};
        end
    end

endmodule

`default_nettype wire

// ===== verilog/lcs_link_map.vh
// Register map, field positions and reset values for the link control
// and self-ID bookkeeping block. Definitions only; included by bare name.
`ifndef LCS_LINK_MAP_VH
`define LCS_LINK_MAP_VH

// Register byte offsets on the host register port
`define LCS_OFS_CTRL_SET 12'h050
`define LCS_OFS_CTRL_CLR 12'h054
`define LCS_OFS_SID_BASE 12'h064
`define LCS_OFS_SID_TALLY 12'h068

// Offset windows that live in the PHY-clock domain
`define LCS_PHY_LO_A 12'h0dc
`define LCS_PHY_HI_A 12'h0f0
`define LCS_PHY_LO_B 12'h100
`define LCS_PHY_HI_B 12'h11c

// Control register bit positions
`define LCS_BIT_POWER 19
`define LCS_BIT_POSTED 18
`define LCS_BIT_ONLINE 17
`define LCS_BIT_REINIT 16

// Self-ID base: writable bits 31..11
`define LCS_BASE_MSB 31
`define LCS_BASE_LSB 11
`define LCS_BASE_W 21

// Self-ID tally fields
`define LCS_TALLY_ERR 31
`define LCS_GEN_MSB 23
`define LCS_GEN_LSB 16
`define LCS_GEN_W 8
`define LCS_SIZE_MSB 10
`define LCS_SIZE_LSB 2
`define LCS_SIZE_W 9

// Reset and answer values
`define LCS_ZERO32 32'h0000_0000
`define LCS_ONES32 32'hffff_ffff
`define LCS_GEN_RST 8'h00
`define LCS_SIZE_RST 9'h000
`define LCS_SIZE_MAX 9'h1ff
`define LCS_BASE_RST 21'h00_0000

// Counter steps and the reset sequencer end value
`define LCS_CNT_ZERO 5'h00
`define LCS_CNT_STEP 5'h01
`define LCS_GEN_STEP 8'h01
`define LCS_SIZE_STEP 9'h001

`endif

// ===== tb/lcs_link_regs_chk.sv
// Port checker for the link control and self-ID register block.
// Assumes a single clk domain with active-low asynchronous rstn.
`include "lcs_link_map.vh"
`timescale 1ns/1ps
`default_nettype none
module lcs_link_regs_chk (
    input wire clk,
    input wire rstn,
    input wire hostReq,
    input wire hostWrite,
    input wire [11:0] hostAddr,
    input wire hostAck,
    input wire hostAbort,
    input wire [31:0] hostRdata,
    input wire abortSuppress,
    input wire phyClkRunning,
    input wire linkPowerOn,
    input wire linkOnline,
    input wire packetsAllowed,
    input wire reinitActive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Five low samples cover the three-flop sync of the clock pin
    wire inPhy = (hostAddr >= `LCS_PHY_LO_A && hostAddr <= `LCS_PHY_HI_A) ||
        (hostAddr >= `LCS_PHY_LO_B && hostAddr <= `LCS_PHY_HI_B);
    wire rd = hostReq && !hostWrite;
    sequence stopAcc;
        (!phyClkRunning)[*5] ##0 (hostReq && inPhy);
    endsequence
    one_answer_a: assert property (hostReq |=> hostAck != hostAbort)
        else $error("no single answer");
    answer_cause_a: assert property ((hostAck || hostAbort) |-> $past(hostReq))
        else $error("answer without request");
    phy_abort_a: assert property (stopAcc ##0 !abortSuppress |=> hostAbort)
        else $error("no abort");
    phy_ones_a: assert property (stopAcc ##0 (abortSuppress && !hostWrite)
        |=> hostAck && hostRdata == `LCS_ONES32) else $error("no all ones");
    ctrl_low_zero_a: assert property (rd && hostAddr == `LCS_OFS_CTRL_SET
        |=> hostRdata[15:0] == 16'h0000) else $error("ctrl low bits");
    base_low_zero_a: assert property (rd && hostAddr == `LCS_OFS_SID_BASE
        |=> hostRdata[10:0] == 11'h000) else $error("base low bits");
    tally_rsvd_a: assert property (rd && hostAddr == `LCS_OFS_SID_TALLY
        |=> (hostRdata & 32'h7f00f803) == 32'h0000_0000) else $error("tally reserved");
    gate_online_a: assert property (packetsAllowed |-> linkOnline && linkPowerOn)
        else $error("packets while off");
    reinit_off_a: assert property (reinitActive |-> !packetsAllowed ##1 !linkOnline)
        else $error("online in reinit");
    cover property (hostAbort);
    cover property (packetsAllowed);
    cover property ($rose(reinitActive));
endmodule
`default_nettype wire

// ===== tb/lcs_far_model.sv
// Far-side model: link core self-ID events and the PHY clock pin.
// Assumes the bench calls its tasks; lines change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module lcs_far_model (
    input wire clk,
    output logic phyClkRunning,
    output logic busResetSeen,
    output logic selfIdStart,
    output logic selfIdQuadlet,
    output logic selfIdFault,
    output logic selfIdDone
);
    // PHY clock starts stopped, as after power-up
    initial begin
        phyClkRunning = 1'b0;
        {busResetSeen, selfIdStart, selfIdQuadlet, selfIdFault, selfIdDone} = 5'h00;
    end
    // One-cycle pulse: 4 bus reset, 3 start, 2 quadlet, 1 fault, 0 done
    task automatic pulse(input int k);
        begin
            @(negedge clk);
            {busResetSeen, selfIdStart, selfIdQuadlet, selfIdFault, selfIdDone} = 5'h01 << k;
            @(negedge clk);
            {busResetSeen, selfIdStart, selfIdQuadlet, selfIdFault, selfIdDone} = 5'h00;
        end
    endtask
    // Bus reset, then start, quadlets, optional fault, done
    task automatic burst(input int n, input logic f);
        begin
            pulse(4);
            pulse(3);
            repeat (n) pulse(2);
            if (f) pulse(1);
            pulse(0);
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_link_control_and_selfid_regs.sv
// Self-checking bench for the link control and self-ID register block.
// Assumes the far model drives events; host strobes at falling edges.
`include "lcs_link_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_link_control_and_selfid_regs;
    logic clk, rstn, hostReq, hostWrite, abortSuppress, ab;
    logic [11:0] hostAddr;
    logic [31:0] hostWdata, q;
    wire hostAck, hostAbort, linkPowerOn, postedWriteAllow, linkOnline, packetsAllowed;
    wire reinitActive, phyClkRunning, busResetSeen, selfIdStart, selfIdQuadlet;
    wire selfIdFault, selfIdDone;
    wire [31:0] hostRdata, selfIdWriteAddr;
    int nErrors = 0, samplesChecked = 0, cyc = 0;
    // Short reinit keeps the run brief, yet the busy bit is read mid-reset
    lcs_link_regs #(.REINIT_CYCLES(4)) DUT (.clk(clk), .rstn(rstn), .hostReq(hostReq),
        .hostWrite(hostWrite), .hostAddr(hostAddr), .hostWdata(hostWdata),
        .hostAck(hostAck), .hostAbort(hostAbort), .hostRdata(hostRdata),
        .abortSuppress(abortSuppress), .phyClkRunning(phyClkRunning),
        .busResetSeen(busResetSeen), .selfIdStart(selfIdStart),
        .selfIdQuadlet(selfIdQuadlet), .selfIdFault(selfIdFault), .selfIdDone(selfIdDone),
        .linkPowerOn(linkPowerOn), .postedWriteAllow(postedWriteAllow),
        .linkOnline(linkOnline), .packetsAllowed(packetsAllowed),
        .reinitActive(reinitActive), .selfIdWriteAddr(selfIdWriteAddr));
    lcs_far_model far (.clk(clk), .phyClkRunning(phyClkRunning),
        .busResetSeen(busResetSeen), .selfIdStart(selfIdStart),
        .selfIdQuadlet(selfIdQuadlet), .selfIdFault(selfIdFault), .selfIdDone(selfIdDone));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard: the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            nErrors++;
            endSim;
        end
    end
    task automatic endSim;
        begin
            if (nErrors == 0 && samplesChecked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            samplesChecked++;
            if (g !== e) begin
                nErrors++;
                $display("Error %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // One-cycle strobe; the answer stands in the following cycle only
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(negedge clk);
            {hostReq, hostWrite, hostAddr, hostWdata} = {1'b1, w, a, d};
            @(negedge clk);
            hostReq = 1'b0;
            ab = hostAbort;
            q = hostRdata;
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        begin
            acc(1'b0, a, 32'h0);
            chk(nm, e, q);
        end
    endtask
    task automatic tPhy;
        begin
            acc(1'b0, 12'h0dc, 32'h0);
            chk("abort dc", 32'h1, {31'h0, ab});
            acc(1'b0, 12'h11c, 32'h0);
            chk("abort 11c", 32'h1, {31'h0, ab});
            acc(1'b0, 12'h0f4, 32'h0);
            chk("abort f4", 32'h0, {31'h0, ab});
            abortSuppress = 1'b1;
            rdc(12'h100, `LCS_ONES32, "suppressed");
            abortSuppress = 1'b0;
            far.phyClkRunning = 1'b1;
            repeat (8) @(negedge clk);
            acc(1'b0, 12'h0f0, 32'h0);
            chk("abort running", 32'h0, {31'h0, ab});
        end
    endtask
    task automatic tRegs;
        begin
            acc(1'b1, `LCS_OFS_CTRL_SET, 32'h000e_ffff);
            rdc(`LCS_OFS_CTRL_CLR, 32'h000e_0000, "ctrl set");
            chk("pkts on", 32'h1, {31'h0, packetsAllowed});
            chk("online out", 32'h1, {31'h0, linkOnline});
            chk("power out", 32'h1, {31'h0, linkPowerOn});
            acc(1'b1, `LCS_OFS_CTRL_CLR, 32'h0006_0000);
            rdc(`LCS_OFS_CTRL_SET, 32'h000c_0000, "posted locked");
            chk("pkts off", 32'h0, {31'h0, packetsAllowed});
            acc(1'b1, `LCS_OFS_CTRL_CLR, 32'h0004_0000);
            @(negedge clk);
            chk("posted", 32'h0, {31'h0, postedWriteAllow});
            acc(1'b1, `LCS_OFS_SID_BASE, `LCS_ONES32);
            rdc(`LCS_OFS_SID_BASE, 32'hffff_f800, "base");
            acc(1'b1, `LCS_OFS_SID_TALLY, `LCS_ONES32);
            rdc(`LCS_OFS_SID_TALLY, 32'h0, "tally write");
        end
    endtask
    task automatic tSelfId;
        begin
            acc(1'b1, `LCS_OFS_SID_BASE, 32'h0001_2800);
            far.burst(2, 1'b0);
            rdc(`LCS_OFS_SID_TALLY, 32'h0, "offline");
            acc(1'b1, `LCS_OFS_CTRL_SET, 32'h0002_0000);
            far.burst(3, 1'b0);
            rdc(`LCS_OFS_SID_TALLY, 32'h0001_000c, "tally 1");
            chk("store addr", 32'h0001_280c, selfIdWriteAddr);
            far.burst(1, 1'b1);
            rdc(`LCS_OFS_SID_TALLY, 32'h8002_0004, "fault");
            far.burst(0, 1'b0);
            rdc(`LCS_OFS_SID_TALLY, 32'h0003_0000, "clean");
            repeat (253) far.pulse(4);
            rdc(`LCS_OFS_SID_TALLY, 32'h0, "wrap");
        end
    endtask
    task automatic tSoft;
        begin
            far.burst(1, 1'b1);
            rdc(`LCS_OFS_SID_TALLY, 32'h8001_0004, "pre reset");
            acc(1'b1, `LCS_OFS_CTRL_SET, 32'h0001_0000);
            acc(1'b0, `LCS_OFS_CTRL_SET, 32'h0);
            chk("busy", 32'h0001_0000, q & 32'h0001_0000);
            chk("reinit out", 32'h1, {31'h0, reinitActive});
            repeat (10) @(negedge clk);
            rdc(`LCS_OFS_CTRL_SET, 32'h0, "ctrl after");
            rdc(`LCS_OFS_SID_BASE, 32'h0, "base after");
            rdc(`LCS_OFS_SID_TALLY, 32'h0, "tally after");
            chk("addr after", 32'h0, selfIdWriteAddr);
        end
    endtask
    initial begin
        {rstn, hostReq, hostWrite, abortSuppress, hostAddr, hostWdata} = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        rdc(`LCS_OFS_CTRL_SET, 32'h0, "ctrl reset");
        tPhy;
        tRegs;
        tSelfId;
        tSoft;
        endSim;
    end
endmodule
bind lcs_link_regs lcs_link_regs_chk chk (.clk(clk), .rstn(rstn), .hostReq(hostReq),
    .hostWrite(hostWrite), .hostAddr(hostAddr), .hostAck(hostAck), .hostAbort(hostAbort),
    .hostRdata(hostRdata), .abortSuppress(abortSuppress), .phyClkRunning(phyClkRunning),
    .linkPowerOn(linkPowerOn), .linkOnline(linkOnline), .packetsAllowed(packetsAllowed),
    .reinitActive(reinitActive));
`default_nettype wire
